// ---- shared/asc_pkg.sv ----
// Purpose: Constants and types for the scan-mode control of a successive-approximation converter
// Assumes: 32-bit classic Wishbone register access, one clock
// Notes: Register offsets are byte addresses
//
// What this block does
// - Scan mode 00b runs one scan over the selected channels, then stops
// - Scan mode 01b is group scan: groups A and B convert on own triggers
// - Group A mask: bit n enables input n; 02h is input 1, 0Eh inputs 1 to 3
// - Group B mask uses the same scheme; 04h places only input 2 in group B
// - Group A trigger code 001001b starts group A on timer channel 4 match A
// - Group B trigger code 001010b starts group B on timer channel 4 match B
// - Writing 1 to the start bit with mode 00b begins a scan, with mode 01b arms the triggers; writing 0 stops it
// - Interrupt enable 1 lets the conversion-end request out; 0 blocks it
// - Conversion-end pending flag clears itself when the interrupt is accepted
// - Source-select write lock is set-once; later writes of 0 have no effect
// - Conversion-end goes through slot 128, gated by that slot's enable bit
package asc_pkg;
   localparam logic [7:0] ASC_OFS_CTRL = 8'h00;
   localparam logic [7:0] ASC_OFS_MASK_A = 8'h04;
   localparam logic [7:0] ASC_OFS_MASK_B = 8'h08;
   localparam logic [7:0] ASC_OFS_TRIG = 8'h0C;
   localparam logic [7:0] ASC_OFS_IRQ = 8'h10;
   localparam logic [7:0] ASC_OFS_STATUS = 8'h14;
   // Control register fields
   localparam int ASC_CTRL_MODE_LSB = 0;
   localparam int ASC_CTRL_IE_BIT = 4;
   localparam int ASC_CTRL_ST_BIT = 7;
   // Trigger register fields
   localparam int ASC_TRIG_B_LSB = 0;
   localparam int ASC_TRIG_A_LSB = 8;
   // Interrupt slot register fields
   localparam int ASC_IRQ_PEND_BIT = 0;
   localparam int ASC_IRQ_EN_BIT = 1;
   localparam int ASC_IRQ_LOCK_BIT = 2;
   localparam int ASC_IRQ_SRC_LSB = 8;
   localparam logic [7:0] ASC_SLOT_VECTOR = 8'h80;
   localparam logic [7:0] ASC_SRC_RESET = 8'h00;
   localparam logic [7:0] ASC_MASK_RESET = 8'h00;
   localparam logic [5:0] ASC_TRIG_RESET = 6'h3F;
   localparam logic [5:0] ASC_TRIG_TMR4_A = 6'h09;
   localparam logic [5:0] ASC_TRIG_TMR4_B = 6'h0A;
   localparam logic [1:0] ASC_MODE_SINGLE = 2'h0;
   localparam logic [1:0] ASC_MODE_GROUP = 2'h1;
   localparam int ASC_CONV_NS = 50;
   localparam int ASC_CLK_NS = 5;
   localparam int ASC_CONV_CYC = (ASC_CONV_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
   typedef enum logic [1:0] {
      ASC_IDLE = 2'b00,
      ASC_SCAN_A = 2'b01,
      ASC_SCAN_B = 2'b10
   } asc_state_t;
endpackage

// ---- core/asc_scan_ctrl.sv ----
// Purpose: Scan-mode sequencer with channel masks, trigger select and interrupt slot
// Assumes: Timer compare-match inputs are one-cycle pulses synchronous to ref_clk_i
// Notes: Analog conversion is modelled only as a fixed per-channel time
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module asc_scan_ctrl
   import asc_pkg::*;
#(
   parameter int NUM_CH = 8,
   parameter int CONV_CYC = ASC_CONV_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tmr4_match_a_i,
   input wire logic tmr4_match_b_i,
   input wire logic irq_accept_i,
   output logic [NUM_CH-1:0] ch_select_o,
   output logic conv_busy_o,
   output logic conv_end_event_o,
   output logic irq_o
);
   localparam int CW = $clog2(NUM_CH);

   logic [1:0] scan_mode_select;
   logic conversion_end_irq_enable;
   logic conversion_start_bit;
   logic [NUM_CH-1:0] group_a_channel_mask;
   logic [NUM_CH-1:0] group_b_channel_mask;
   logic [5:0] group_a_trigger_select;
   logic [5:0] group_b_trigger_select;
   logic pending_request_flag_slot;
   logic slot_irq_enable_bit;
   logic source_select_write_lock;
   logic [7:0] slot_source;
   asc_state_t state;
   logic [CW-1:0] ch_idx;
   logic [15:0] conv_cnt;
   logic pend_a;
   logic pend_b;

   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_ctrl = bus_wr && wb_adr_i == ASC_OFS_CTRL;
   wire wr_mask_a = bus_wr && wb_adr_i == ASC_OFS_MASK_A;
   wire wr_mask_b = bus_wr && wb_adr_i == ASC_OFS_MASK_B;
   wire wr_trig = bus_wr && wb_adr_i == ASC_OFS_TRIG && wb_sel_i[1];
   wire wr_irq = bus_wr && wb_adr_i == ASC_OFS_IRQ;
   wire wr_src = wr_irq && wb_sel_i[1] && !source_select_write_lock;
   wire group_mode = scan_mode_select == ASC_MODE_GROUP;
   wire trig_a = group_mode && conversion_start_bit && (
      (group_a_trigger_select == ASC_TRIG_TMR4_A && tmr4_match_a_i) ||
      (group_a_trigger_select == ASC_TRIG_TMR4_B && tmr4_match_b_i));
   wire trig_b = group_mode && conversion_start_bit && (
      (group_b_trigger_select == ASC_TRIG_TMR4_B && tmr4_match_b_i) ||
      (group_b_trigger_select == ASC_TRIG_TMR4_A && tmr4_match_a_i));
   wire [NUM_CH-1:0] cur_mask = (state == ASC_SCAN_B) ? group_b_channel_mask : group_a_channel_mask;
   wire conv_done = state != ASC_IDLE && conv_cnt == 16'(CONV_CYC - 1);

   // Next enabled channel above the current one, per bit of the mask
   logic [NUM_CH-1:0] above;
   logic [CW-1:0] next_idx;
   logic next_found;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_above
         assign above[g] = cur_mask[g] && (CW'(g) > ch_idx);
      end
   endgenerate
   always_comb begin
      next_idx = '0;
      next_found = 1'b0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (above[i]) begin
            next_idx = CW'(i);
            next_found = 1'b1;
         end
      end
   end

   function automatic logic [CW:0] first_ch(input logic [NUM_CH-1:0] m);
      logic [CW:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = {1'b1, CW'(i)};
         end
      end
      return r;
   endfunction

   wire [CW:0] first_a = first_ch(group_a_channel_mask);
   wire [CW:0] first_b = first_ch(group_b_channel_mask);
   // Only a write that selects single scan may start by software
   wire wr_single = wb_dat_i[ASC_CTRL_MODE_LSB +: 2] == ASC_MODE_SINGLE;
   wire start_sw = wr_ctrl && wb_dat_i[ASC_CTRL_ST_BIT] && !conversion_start_bit && wr_single;
   wire scan_end = conv_done && !next_found;
   wire single_end = scan_end && !group_mode;
   wire end_event = scan_end && conversion_end_irq_enable;
   wire stop_req = wr_ctrl && !wb_dat_i[ASC_CTRL_ST_BIT];
   // A pending trigger is cleared only when its scan really starts or a stop is written
   wire take_sw = start_sw && first_a[CW];
   wire take_a = state == ASC_IDLE && !take_sw && pend_a && first_a[CW];
   wire take_b = state == ASC_IDLE && !take_sw && !(pend_a && first_a[CW]) && pend_b && first_b[CW];

   // Register file
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scan_mode_select <= ASC_MODE_SINGLE;
         conversion_end_irq_enable <= 1'b0;
         group_a_channel_mask <= NUM_CH'(ASC_MASK_RESET);
         group_b_channel_mask <= NUM_CH'(ASC_MASK_RESET);
         group_a_trigger_select <= ASC_TRIG_RESET;
         group_b_trigger_select <= ASC_TRIG_RESET;
         slot_irq_enable_bit <= 1'b0;
         source_select_write_lock <= 1'b0;
         slot_source <= ASC_SRC_RESET;
      end else begin
         if (wr_ctrl) begin
            scan_mode_select <= wb_dat_i[ASC_CTRL_MODE_LSB +: 2];
            conversion_end_irq_enable <= wb_dat_i[ASC_CTRL_IE_BIT];
         end
         if (wr_mask_a) group_a_channel_mask <= wb_dat_i[NUM_CH-1:0];
         if (wr_mask_b) group_b_channel_mask <= wb_dat_i[NUM_CH-1:0];
         if (wr_trig) begin
            group_a_trigger_select <= wb_dat_i[ASC_TRIG_A_LSB +: 6];
            group_b_trigger_select <= wb_dat_i[ASC_TRIG_B_LSB +: 6];
         end
         if (wr_irq) begin
            slot_irq_enable_bit <= wb_dat_i[ASC_IRQ_EN_BIT];
            source_select_write_lock <= source_select_write_lock | wb_dat_i[ASC_IRQ_LOCK_BIT];
         end
         if (wr_src) slot_source <= wb_dat_i[ASC_IRQ_SRC_LSB +: 8];
      end
   end

   // Start bit and slot pending flag; hardware set wins over clears
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conversion_start_bit <= 1'b0;
         pending_request_flag_slot <= 1'b0;
      end else begin
         if (wr_ctrl) conversion_start_bit <= wb_dat_i[ASC_CTRL_ST_BIT];
         if (single_end && !(wr_ctrl && wb_dat_i[ASC_CTRL_ST_BIT])) conversion_start_bit <= 1'b0;
         if (end_event) pending_request_flag_slot <= 1'b1;
         else if (irq_accept_i && irq_o) pending_request_flag_slot <= 1'b0;
         else if (wr_irq && !wb_dat_i[ASC_IRQ_PEND_BIT]) pending_request_flag_slot <= 1'b0;
      end
   end

   // Scan sequencer
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ASC_IDLE;
         ch_idx <= '0;
         conv_cnt <= '0;
         pend_a <= 1'b0;
         pend_b <= 1'b0;
      end else begin
         pend_a <= (pend_a || trig_a) && !(stop_req || take_a);
         pend_b <= (pend_b || trig_b) && !(stop_req || take_b);
         conv_cnt <= (state == ASC_IDLE || conv_done) ? '0 : conv_cnt + 16'h0001;
         if (stop_req) begin
            state <= ASC_IDLE;
         end else begin
            case (state)
               ASC_IDLE: begin
                  if (take_sw) begin
                     state <= ASC_SCAN_A;
                     ch_idx <= first_a[CW-1:0];
                  end else if (take_a) begin
                     state <= ASC_SCAN_A;
                     ch_idx <= first_a[CW-1:0];
                  end else if (take_b) begin
                     state <= ASC_SCAN_B;
                     ch_idx <= first_b[CW-1:0];
                  end
               end
               ASC_SCAN_A, ASC_SCAN_B: begin
                  if (conv_done) begin
                     if (next_found) ch_idx <= next_idx;
                     else state <= ASC_IDLE;
                  end
               end
               default: state <= ASC_IDLE;
            endcase
         end
      end
   end

   // Read mux and outputs
   logic [31:0] rd_data;
   always_comb begin
      rd_data = 32'h00000000;
      case (wb_adr_i)
         ASC_OFS_CTRL: begin
            rd_data[ASC_CTRL_MODE_LSB +: 2] = scan_mode_select;
            rd_data[ASC_CTRL_IE_BIT] = conversion_end_irq_enable;
            rd_data[ASC_CTRL_ST_BIT] = conversion_start_bit;
         end
         ASC_OFS_MASK_A: rd_data[NUM_CH-1:0] = group_a_channel_mask;
         ASC_OFS_MASK_B: rd_data[NUM_CH-1:0] = group_b_channel_mask;
         ASC_OFS_TRIG: begin
            rd_data[ASC_TRIG_A_LSB +: 6] = group_a_trigger_select;
            rd_data[ASC_TRIG_B_LSB +: 6] = group_b_trigger_select;
         end
         ASC_OFS_IRQ: begin
            rd_data[ASC_IRQ_PEND_BIT] = pending_request_flag_slot;
            rd_data[ASC_IRQ_EN_BIT] = slot_irq_enable_bit;
            rd_data[ASC_IRQ_LOCK_BIT] = source_select_write_lock;
            rd_data[ASC_IRQ_SRC_LSB +: 8] = slot_source;
            rd_data[23:16] = ASC_SLOT_VECTOR;
         end
         ASC_OFS_STATUS: begin
            rd_data[1:0] = state;
            rd_data[8 +: CW] = ch_idx;
         end
         default: rd_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ch_select_o <= '0;
         conv_busy_o <= 1'b0;
         conv_end_event_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h00000000;
         ch_select_o <= (state == ASC_IDLE) ? '0 : (NUM_CH'(1) << ch_idx);
         conv_busy_o <= state != ASC_IDLE;
         conv_end_event_o <= end_event;
         irq_o <= (pending_request_flag_slot || end_event) && slot_irq_enable_bit
            && !(irq_accept_i && irq_o);
      end
   end
endmodule // asc_scan_ctrl

// ---- dv/asc_scan_ctrl_properties.sv ----
// Purpose: Port checks of the scan controller
// Assumes: One clock, reset async high
// Notes: Bound to every asc_scan_ctrl
`timescale 1ns/1ps
module asc_scan_ctrl_chk #(
   parameter int NUM_CH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic tmr4_match_a_i,
   input wire logic tmr4_match_b_i,
   input wire logic irq_accept_i,
   input wire logic [NUM_CH-1:0] ch_select_o,
   input wire logic conv_busy_o,
   input wire logic conv_end_event_o,
   input wire logic irq_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_idle_no_sel: assert property (!conv_busy_o |-> ch_select_o == '0)
      else $error("channel while idle");
   a_sel_onehot: assert property ($onehot0(ch_select_o))
      else $error("channel not one-hot");
   a_sel_dwell: assert property (ch_select_o != '0 && $changed(ch_select_o) |=> $stable(ch_select_o))
      else $error("channel too short");
   a_event_pulse: assert property (conv_end_event_o |=> !conv_end_event_o)
      else $error("event too long");
   a_event_scan: assert property (conv_end_event_o |-> $past(conv_busy_o) || $past(conv_busy_o, 2))
      else $error("event without scan");
   a_accept_clears: assert property (irq_o && irq_accept_i && !conv_end_event_o |-> ##[1:2] !irq_o)
      else $error("irq not cleared");
endmodule // asc_scan_ctrl_chk
bind asc_scan_ctrl asc_scan_ctrl_chk #(.NUM_CH(NUM_CH)) asc_scan_ctrl_chk_i (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tmr4_match_a_i(tmr4_match_a_i),
   .tmr4_match_b_i(tmr4_match_b_i), .irq_accept_i(irq_accept_i), .ch_select_o(ch_select_o),
   .conv_busy_o(conv_busy_o), .conv_end_event_o(conv_end_event_o), .irq_o(irq_o));

// ---- dv/asc_tmr_icu_model.sv ----
// Purpose: Timer match source and interrupt acceptor
// Assumes: Fire inputs are one-cycle pulses
// Notes: Accepts a standing request after ACK_DLY cycles
`timescale 1ns/1ps
module asc_tmr_icu_model #(
   parameter int ACK_DLY = 3
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic fire_a_i,
   input wire logic fire_b_i,
   input wire logic irq_i,
   output logic match_a_o,
   output logic match_b_o,
   output logic accept_o
);
   logic [3:0] wait_cnt;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         match_a_o <= 1'b0;
         match_b_o <= 1'b0;
         accept_o <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         match_a_o <= fire_a_i;
         match_b_o <= fire_b_i;
         accept_o <= 1'b0;
         wait_cnt <= irq_i ? wait_cnt + 4'h1 : 4'h0;
         if (irq_i && wait_cnt == 4'(ACK_DLY)) begin
            accept_o <= 1'b1;
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule // asc_tmr_icu_model

// ---- dv/asc_scan_ctrl_test.sv ----
// Purpose: Register-level test of the scan controller
// Assumes: Classic Wishbone, 200 MHz
// Notes: Short conversion time
`timescale 1ns/1ps
module asc_scan_ctrl_test import asc_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic fa = 1'b0;
   logic fb = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rd;
   logic [31:0] dat_o;
   logic [7:0] sel_o;
   logic ack, busy, ev, irq, acc, ma, mb;
   int failures = 0;
   int check_count = 0;
   int ev_count = 0;
   int acc_count = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (ev === 1'b1) ev_count <= ev_count + 1;
      if (acc === 1'b1) acc_count <= acc_count + 1;
   end
   asc_scan_ctrl #(.CONV_CYC(4)) asc_scan_ctrl_i (.ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .tmr4_match_a_i(ma), .tmr4_match_b_i(mb),
      .irq_accept_i(acc), .ch_select_o(sel_o), .conv_busy_o(busy), .conv_end_event_o(ev), .irq_o(irq));
   asc_tmr_icu_model asc_tmr_icu_model_i (.ref_clk_i(clk), .rst_i(rst), .fire_a_i(fa), .fire_b_i(fb),
      .irq_i(irq), .match_a_o(ma), .match_b_o(mb), .accept_o(acc));
   task automatic finish_test;
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      chk("ack", 32'h1, 32'(n < 40));
      if (n == 40) finish_test();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   task automatic wait_on(input logic [7:0] e, input logic idle);
      int n;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (idle ? busy === 1'b0 : sel_o === e) break;
      end
      chk("wait", 32'h1, 32'(n < 100));
      if (n == 100) finish_test();
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ASC_OFS_CTRL, 32'h0);
      rd_chk(ASC_OFS_MASK_A, 32'h0);
      rd_chk(ASC_OFS_TRIG, 32'h3F3F);
      rd_chk(ASC_OFS_IRQ, 32'h00800000);
      rd_chk(8'h20, 32'h0);
      xfer(1'b1, ASC_OFS_IRQ, 32'h4004);
      xfer(1'b1, ASC_OFS_IRQ, 32'h0002);
      rd_chk(ASC_OFS_IRQ, 32'h00804006);
      xfer(1'b1, ASC_OFS_MASK_A, 32'h0E);
      xfer(1'b1, ASC_OFS_CTRL, 32'h90);
      wait_on(8'h02, 1'b0);
      wait_on(8'h04, 1'b0);
      wait_on(8'h08, 1'b0);
      wait_on(8'h00, 1'b1);
      repeat (10) @(posedge clk);
      chk("events", 32'h1, 32'(ev_count));
      chk("accepts", 32'h1, 32'(acc_count));
      chk("irq", 32'h0, {31'h0, irq});
      rd_chk(ASC_OFS_CTRL, 32'h10);
      rd_chk(ASC_OFS_IRQ, 32'h00804006);
      xfer(1'b1, ASC_OFS_MASK_A, 32'h02);
      xfer(1'b1, ASC_OFS_CTRL, 32'h80);
      wait_on(8'h02, 1'b0);
      wait_on(8'h00, 1'b1);
      repeat (10) @(posedge clk);
      chk("events", 32'h1, 32'(ev_count));
      xfer(1'b1, ASC_OFS_MASK_A, 32'h0E);
      xfer(1'b1, ASC_OFS_CTRL, 32'h80);
      wait_on(8'h02, 1'b0);
      rd_chk(ASC_OFS_STATUS, 32'h00000101);
      xfer(1'b1, ASC_OFS_CTRL, 32'h00);
      chk("stop", 32'h0, {23'h0, busy, sel_o});
      xfer(1'b1, ASC_OFS_CTRL, 32'h82);
      repeat (8) @(posedge clk);
      chk("mode2", 32'h0, {23'h0, busy, sel_o});
      xfer(1'b1, ASC_OFS_MASK_A, 32'h02);
      xfer(1'b1, ASC_OFS_MASK_B, 32'h04);
      rd_chk(ASC_OFS_MASK_B, 32'h04);
      xfer(1'b1, ASC_OFS_TRIG, 32'h090A);
      xfer(1'b1, ASC_OFS_CTRL, 32'h81);
      fb <= 1'b1;
      @(posedge clk);
      fb <= 1'b0;
      wait_on(8'h04, 1'b0);
      wait_on(8'h00, 1'b1);
      fa <= 1'b1;
      @(posedge clk);
      fa <= 1'b0;
      wait_on(8'h02, 1'b0);
      wait_on(8'h00, 1'b1);
      finish_test();
   end
endmodule // asc_scan_ctrl_test
